// >>> core/lsi_mix_pwm.sv
// Eight-step duty generator that mixes the two colours of a lamp pair.
`timescale 1ns/1ps
module lsi_mix_pwm
   import lsi_pkg::*;
(
   input  wire logic                        core_clk,   // Core clock.
   input  wire logic                        arst_n,     // Async reset.
   input  wire logic [lsi_pkg::RATIO_W-1:0] ratio_even, // Even duty.
   input  wire logic [lsi_pkg::RATIO_W-1:0] ratio_odd,  // Odd duty.
   output logic                             mix_even,   // Even level.
   output logic                             mix_odd     // Odd level.
);

   logic [2:0] phase;

   // Free-running step counter; one full period is eight core cycles.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase <= 3'h0;
      end else begin
         phase <= phase + 3'h1;
      end
   end

   // Even lamp lights at the start of the period, odd at its end, so two
   // ratios summing to at most full scale never overlap on one lamp.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mix_even <= 1'b0;
         mix_odd  <= 1'b0;
      end else begin
         mix_even <= (ratio_even >= MIX_FULL) ||
                     (phase < ratio_even[2:0]);
         mix_odd  <= (ratio_odd >= MIX_FULL) ||
                     ((ratio_odd[2:0] != MIX_ZERO) &&
                      (phase >= (MIX_ZERO - ratio_odd[2:0])));
      end
   end

endmodule : lsi_mix_pwm

// >>> core/lsi_pkg.sv
// Constants, codes and helper functions shared by the indicator block.
package lsi_pkg;

   // Core clock and the millisecond timebase derived from it.
   localparam int CLK_PERIOD_NS  = 100;
   localparam int TICK_PERIOD_NS = 1_000_000;
   localparam int MS_CYCLES      = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
   localparam int TICK_CNT_W     = 14;

   // Output count and field widths.
   localparam int NUM_OUT  = 6;
   localparam int CODE_W   = 4;
   localparam int CTRL_W   = NUM_OUT * CODE_W;
   localparam int OFFV_W   = 2;
   localparam int OFFVS_W  = NUM_OUT * OFFV_W;
   localparam int RATIO_W  = 4;
   localparam int SEL_W    = 2;
   localparam int DUR_W    = 10;
   localparam int SEG_W    = 3;
   localparam int STAT_W   = 8;

   // Segment and blink durations in milliseconds, one per select code.
   localparam logic [DUR_W-1:0] DUR_MS_0 = 10'h054;
   localparam logic [DUR_W-1:0] DUR_MS_1 = 10'h0aa;
   localparam logic [DUR_W-1:0] DUR_MS_2 = 10'h154;
   localparam logic [DUR_W-1:0] DUR_MS_3 = 10'h29e;

   // Control field codes.
   localparam logic [CODE_W-1:0] CODE_SPEED   = 4'h2;
   localparam logic [1:0]        PFX_FORCE    = 2'h2;
   localparam logic [1:0]        PFX_DUAL     = 2'h3;
   localparam logic [1:0]        FORCE_OFF    = 2'h0;
   localparam logic [1:0]        FORCE_ON     = 2'h1;
   localparam logic [1:0]        FORCE_HIZ    = 2'h2;
   localparam logic [1:0]        FORCE_BLINK  = 2'h3;

   // Speed blink segments, counted from zero.
   localparam logic [SEG_W-1:0] SEG_FIRST = 3'h0;
   localparam logic [SEG_W-1:0] SEG_THIRD = 3'h2;
   localparam logic [SEG_W-1:0] SEG_FIFTH = 3'h4;
   localparam logic [SEG_W-1:0] SEG_LAST  = 3'h7;

   // Mixing ratio in eighths; codes at or above full scale light fully.
   localparam logic [RATIO_W-1:0] MIX_FULL = 4'h8;
   localparam logic [2:0]         MIX_ZERO = 3'h0;

   // Status vector bit positions.
   localparam int ST_L10  = 0;
   localparam int ST_L100 = 1;
   localparam int ST_L1G  = 2;
   localparam int ST_FIB  = 3;
   localparam int ST_RX   = 4;
   localparam int ST_TX   = 5;
   localparam int ST_FDX  = 6;
   localparam int ST_COL  = 7;

   // Dual-output modes selected by the low bits of an even control field.
   typedef enum logic [1:0] {
      LSI_DUAL_SOLID = 2'b00,
      LSI_DUAL_BLINK = 2'b01,
      LSI_DUAL_SPD_A = 2'b10,
      LSI_DUAL_SPD_B = 2'b11
   } lsi_dual_e;

   // Duration lookup shared by segment timing and blink rate.
   function automatic logic [DUR_W-1:0] lsi_dur(input logic [SEL_W-1:0] sel);
      case (sel)
         2'h0:    lsi_dur = DUR_MS_0;
         2'h1:    lsi_dur = DUR_MS_1;
         2'h2:    lsi_dur = DUR_MS_2;
         default: lsi_dur = DUR_MS_3;
      endcase
   endfunction : lsi_dur

endpackage : lsi_pkg

// >>> core/lsi_speed_seq.sv
// Eight-segment speed blink sequencer timed by the millisecond tick.
`timescale 1ns/1ps
module lsi_speed_seq
   import lsi_pkg::*;
(
   input  wire logic                      core_clk, // Core clock.
   input  wire logic                      arst_n,   // Async reset.
   input  wire logic                      ms_tick,  // One-cycle ms pulse.
   input  wire logic [lsi_pkg::SEL_W-1:0] odd_sel,  // Odd segment time.
   input  wire logic [lsi_pkg::SEL_W-1:0] even_sel, // Even segment time.
   input  wire logic                      spd_10,   // 10 Mbps link.
   input  wire logic                      spd_100,  // 100 Mbps link.
   input  wire logic                      spd_1g,   // Gigabit link.
   output logic                           speed_on  // Pattern level.
);

   logic [SEG_W-1:0] seg;
   logic [DUR_W-1:0] elapsed;
   logic [DUR_W-1:0] cur_dur;
   logic             seg_done;

   // Segment index zero is segment one, so even indices are odd segments.
   assign cur_dur  = seg[0] ? lsi_dur(even_sel) : lsi_dur(odd_sel);
   assign seg_done = ms_tick && (elapsed >= cur_dur - 10'h001);

   // Elapsed time restarts at each boundary; the index wraps after eight.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         elapsed <= 10'h000;
         seg     <= SEG_FIRST;
      end else if (seg_done) begin
         elapsed <= 10'h000;
         seg     <= seg + 3'h1;
      end else if (ms_tick) begin
         elapsed <= elapsed + 10'h001;
      end
   end

   // Pulses in segments one, three and five by link speed.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         speed_on <= 1'b0;
      end else begin
         speed_on <= ((seg == SEG_FIRST) && (spd_10 || spd_100 || spd_1g)) ||
                     ((seg == SEG_THIRD) && (spd_100 || spd_1g)) ||
                     ((seg == SEG_FIFTH) && spd_1g);
      end
   end

   default clocking seq_cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   sequence last_seg_ends;
      (seg == SEG_LAST) && seg_done;
   endsequence

   seg_wrap_a: assert property (last_seg_ends |=> seg == SEG_FIRST)
      else $error("speed pattern did not restart at segment one");
   seg_hold_a: assert property (!seg_done |=> $stable(seg))
      else $error("segment advanced before its time ran out");
   seg_len_a: assert property (elapsed < cur_dur)
      else $error("segment ran longer than its selected time");
   off_segs_a: assert property (seg > SEG_FIFTH |=> !speed_on)
      else $error("pattern lit outside the pulse segments");

endmodule : lsi_speed_seq

// >>> core/lsi_top.sv
// Six-output status indicator driver with speed blink and dual modes.
// Functional notes
// - Activity is transmit or receive activity.
// - Copper link is any copper speed link.
// - Link is copper link or fiber link.
// - Output zero speed code selects blink pattern.
// - Pattern has eight segments, repeating forever.
// - Pulse count three, two, one by speed.
// - Odd and even segments use separate durations.
// - Duration codes: 84, 170, 340, 670 ms.
// - Upper bits 10 force on/off/hi-z/blink.
// - Forcing lights one colour; dual modes mix.
// - Even field code 11xx sets pair dual mode.
// - First dual mode shows steady mixed colour.
// - Second dual mode blinks the mixed colour.
// - Third dual mode colours by link speed.
// - Fourth dual mode swaps 10 and 100.
// - Low power puts unforced outputs inactive.
// - Forced on, off and hi-z outputs keep value in any state.
// - Forced blink does not blink in low power.
// - Low power unforced level from off-value field.
// - Powered up, outputs follow configured function.
// - Mix ratio in eighths, 1000 is full.
`timescale 1ns/1ps
module lsi_top
   import lsi_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = lsi_pkg::MS_CYCLES // Cycles per ms.
)(
   input  wire logic                        core_clk,          // Core clock.
   input  wire logic                        arst_n,            // Async reset.
   input  wire logic                        tx_act,            // Tx activity.
   input  wire logic                        rx_act,            // Rx activity.
   input  wire logic                        link10,            // 10 link up.
   input  wire logic                        link100,           // 100 link up.
   input  wire logic                        link1000,          // 1G link up.
   input  wire logic                        fiber_link,        // Fiber link.
   input  wire logic                        full_duplex,       // Full duplex.
   input  wire logic                        collision,         // Collision.
   input  wire logic                        sw_reset,          // Soft reset.
   input  wire logic                        power_down,        // Powered down.
   input  wire logic                        energy_detect,     // Energy sleep.
   input  wire logic [lsi_pkg::CTRL_W-1:0]  ind_ctrl,          // Fields.
   input  wire logic [lsi_pkg::RATIO_W-1:0] mix_ratio_even,    // Even mix.
   input  wire logic [lsi_pkg::RATIO_W-1:0] mix_ratio_odd,     // Odd mix.
   input  wire logic [lsi_pkg::SEL_W-1:0]   seg_odd_sel,       // Odd time.
   input  wire logic [lsi_pkg::SEL_W-1:0]   seg_even_sel,      // Even time.
   input  wire logic [lsi_pkg::SEL_W-1:0]   blink_sel,         // Blink time.
   input  wire logic [lsi_pkg::OFFVS_W-1:0] off_value,         // Off levels.
   output logic [lsi_pkg::NUM_OUT-1:0]      indicator_outputs, // Levels.
   output logic [lsi_pkg::NUM_OUT-1:0]      indicator_oe_n     // Enables.
);

   logic [TICK_CNT_W-1:0] tick_cnt;
   logic                  ms_tick;
   logic [DUR_W-1:0]      blink_ms;
   logic                  blink_phase;
   logic                  activity;
   logic                  copper_link;
   logic                  any_link;
   logic                  gig_link;
   logic                  low_power;
   logic [STAT_W-1:0]     status;
   logic                  speed_lvl;
   logic                  mix_even;
   logic                  mix_odd;
   logic [NUM_OUT-1:0]    next_lvl;
   logic [NUM_OUT-1:0]    next_oe_n;

   // Compound terms; fiber counts as a gigabit link for the speed blink and dual speed modes.
   assign activity    = tx_act || rx_act;
   assign copper_link = link10 || link100 || link1000;
   assign any_link    = copper_link || fiber_link;
   assign gig_link    = link1000 || fiber_link;
   assign low_power   = sw_reset || power_down || energy_detect;
   assign status      = {collision, full_duplex, tx_act, rx_act,
                         fiber_link, link1000, link100, link10};

   // Millisecond tick divider; the count is a parameter so that a
   // simulation can run the slow patterns quickly.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt <= '0;
         ms_tick  <= 1'b0;
      end else if (tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1)) begin
         tick_cnt <= '0;
         ms_tick  <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 14'h0001;
         ms_tick  <= 1'b0;
      end
   end

   // Blink square wave; each half period lasts the selected duration.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         blink_ms    <= 10'h000;
         blink_phase <= 1'b0;
      end else if (ms_tick) begin
         if (blink_ms >= lsi_dur(blink_sel) - 10'h001) begin
            blink_ms    <= 10'h000;
            blink_phase <= !blink_phase;
         end else begin
            blink_ms <= blink_ms + 10'h001;
         end
      end
   end

   lsi_speed_seq u_speed (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .ms_tick  (ms_tick),
      .odd_sel  (seg_odd_sel),
      .even_sel (seg_even_sel),
      .spd_10   (link10),
      .spd_100  (link100),
      .spd_1g   (gig_link),
      .speed_on (speed_lvl)
   );

   lsi_mix_pwm u_mix (
      .core_clk   (core_clk),
      .arst_n     (arst_n),
      .ratio_even (mix_ratio_even),
      .ratio_odd  (mix_ratio_odd),
      .mix_even   (mix_even),
      .mix_odd    (mix_odd)
   );

   // Steady display functions; returns lit and blink-while-lit flags.
   function automatic logic [1:0] single_mode(input int idx,
                                              input logic [3:0] code,
                                              input logic [STAT_W-1:0] st);
      logic act;
      logic cop;
      logic lnk;
      act = st[ST_TX] || st[ST_RX];
      cop = st[ST_L10] || st[ST_L100] || st[ST_L1G];
      lnk = cop || st[ST_FIB];
      single_mode = 2'b00;
      case (code)
         4'h0: begin
            if (idx == 1) single_mode = {cop, 1'b0};
            else if (idx == 3) single_mode = {st[ST_FIB], 1'b0};
            else if (idx >= 4) single_mode = {st[ST_RX], 1'b0};
            else single_mode = {lnk, 1'b0};
         end
         4'h1: single_mode = {lnk, act};
         4'h2: single_mode = {lnk && (idx != 2), st[ST_RX]};
         4'h3: single_mode = {act, 1'b0};
         4'h4: single_mode = {act, act};
         4'h5: begin
            if (idx == 1) single_mode = {st[ST_L100] || st[ST_FIB], 1'b0};
            else if (idx == 3) single_mode = 2'b00;
            else single_mode = {st[ST_TX], 1'b0};
         end
         4'h6: begin
            if (idx == 0) single_mode = {cop, 1'b0};
            else if (idx == 1) single_mode = {st[ST_L100], 1'b0};
            else if (idx <= 3) single_mode = {st[ST_L10] || st[ST_L1G], 1'b0};
            else single_mode = {st[ST_FDX], 1'b0};
         end
         4'h7: begin
            if (idx == 0) single_mode = {st[ST_L1G], 1'b0};
            else if (idx == 1) single_mode = {st[ST_L100], 1'b0};
            else if (idx == 2) single_mode = {st[ST_L10], 1'b0};
            else if (idx == 3) single_mode = {st[ST_FDX], 1'b0};
            else single_mode = {st[ST_FDX], st[ST_COL]};
         end
         default: single_mode = 2'b00;
      endcase
   endfunction : single_mode

   // Per-output selection. Priority: forced, low power, dual pair, speed
   // blink, steady function. An odd output whose even neighbour is in a
   // dual mode ignores its own field, forced codes included.
   for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
      localparam int EVN = i - (i % 2);
      localparam bit IS_EVEN = (i % 2) == 0;
      logic [3:0]  code;
      logic        pair_dual;
      lsi_dual_e   dmode;
      logic        mix_me;
      logic        gate;
      logic [1:0]  fn;
      logic        nl;
      logic        no;
      assign code      = ind_ctrl[CODE_W*i +: CODE_W];
      assign pair_dual = ind_ctrl[CODE_W*EVN+2 +: 2] == PFX_DUAL;
      assign dmode     = lsi_dual_e'(ind_ctrl[CODE_W*EVN +: 2]);
      assign mix_me    = IS_EVEN ? mix_even : mix_odd;
      assign gate      = !activity || blink_phase;
      assign fn        = single_mode(i, code, status);
      always_comb begin
         nl = 1'b0;
         no = 1'b0;
         if (code[3:2] == PFX_FORCE && !(pair_dual && !IS_EVEN)) begin
            // One pin per colour only, so forcing never mixes.
            case (code[1:0])
               FORCE_OFF:   nl = 1'b0;
               FORCE_ON:    nl = 1'b1;
               FORCE_HIZ:   no = 1'b1;
               FORCE_BLINK: nl = blink_phase && !low_power;
               default:     nl = 1'b0;
            endcase
         end else if (low_power) begin
            nl = off_value[OFFV_W*i];
            no = off_value[OFFV_W*i+1];
         end else if (pair_dual) begin
            case (dmode)
               LSI_DUAL_SOLID: nl = mix_me;
               LSI_DUAL_BLINK: nl = mix_me && blink_phase;
               LSI_DUAL_SPD_A,
               LSI_DUAL_SPD_B: begin
                  if (gig_link) nl = IS_EVEN && gate;
                  else if (link100 && dmode == LSI_DUAL_SPD_A)
                     nl = mix_me && gate;
                  else if (link100) nl = !IS_EVEN && gate;
                  else if (link10 && dmode == LSI_DUAL_SPD_B)
                     nl = mix_me && gate;
                  else if (link10) nl = !IS_EVEN && gate;
                  else nl = 1'b0;
               end
               default: nl = 1'b0;
            endcase
         end else if (i == 0 && code == CODE_SPEED) begin
            nl = speed_lvl;
         end else begin
            nl = fn[1] && (!fn[0] || blink_phase);
         end
      end
      assign next_lvl[i]  = nl;
      assign next_oe_n[i] = no;
   end

   // Registered pins; outputs drive low until the first decision.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         indicator_outputs <= '0;
         indicator_oe_n    <= '0;
      end else begin
         indicator_outputs <= next_lvl;
         indicator_oe_n    <= next_oe_n;
      end
   end

   default clocking top_cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   sequence lp_held;
      (ind_ctrl[3:0] == 4'hb && low_power)[*3];
   endsequence

   sequence solid_mix_full;
      (ind_ctrl[3:0] == 4'hc && !low_power &&
       mix_ratio_even == MIX_FULL && mix_ratio_odd == 4'h0)[*2];
   endsequence

   act_term_a: assert property (ind_ctrl[3:0] == 4'h3 && !low_power |=>
      indicator_outputs[0] == ($past(tx_act) || $past(rx_act)))
      else $error("activity display does not follow tx or rx");
   copper_term_a: assert property (ind_ctrl[7:4] == 4'h0 &&
      ind_ctrl[3:2] != PFX_DUAL && !low_power |=> indicator_outputs[1] ==
      ($past(link10) || $past(link100) || $past(link1000)))
      else $error("copper link display is wrong");
   link_term_a: assert property (ind_ctrl[11:8] == 4'h0 && !low_power |=>
      indicator_outputs[2] == ($past(link10) || $past(link100) ||
      $past(link1000) || $past(fiber_link)))
      else $error("link display is wrong");
   speed_pick_a: assert property (ind_ctrl[3:0] == CODE_SPEED &&
      !low_power |=> indicator_outputs[0] == $past(speed_lvl))
      else $error("output zero does not show the speed pattern");
   forced_on_a: assert property (ind_ctrl[3:0] == 4'h9 |=>
      indicator_outputs[0] && !indicator_oe_n[0])
      else $error("forced on output not driven high");
   forced_hiz_a: assert property (ind_ctrl[3:0] == 4'ha |=>
      indicator_oe_n[0])
      else $error("forced hi-z output still driven");
   lp_noblink_a: assert property (lp_held |=>
      !indicator_outputs[0])
      else $error("forced blink toggles in low power");
   lp_offval_a: assert property (ind_ctrl[7:4] == 4'h0 &&
      ind_ctrl[3:2] != PFX_DUAL && low_power |=>
      indicator_outputs[1] == $past(off_value[2]) &&
      indicator_oe_n[1] == $past(off_value[3]))
      else $error("low power level differs from off value");
   mix_solid_a: assert property (solid_mix_full |=>
      indicator_outputs[0] && !indicator_outputs[1])
      else $error("solid mix does not follow the ratios");
   mix_blink_a: assert property (ind_ctrl[3:0] == 4'hd && !low_power &&
      !blink_phase |=> !indicator_outputs[0] && !indicator_outputs[1])
      else $error("blink mix lit in the dark half");
   mode3_gig_a: assert property (ind_ctrl[3:0] == 4'he && !low_power &&
      link1000 && !activity |=>
      indicator_outputs[0] && !indicator_outputs[1])
      else $error("third dual mode gigabit colour wrong");
   mode4_100_a: assert property (ind_ctrl[3:0] == 4'hf && !low_power &&
      link100 && !gig_link && !activity |=>
      indicator_outputs[1] && !indicator_outputs[0])
      else $error("fourth dual mode 100 colour wrong");
   tick_gap_a: assert property (ms_tick |=> !ms_tick)
      else $error("millisecond tick longer than one cycle");

   // Cycles since the last tick, counted apart from the divider so that
   // a wrong reload value cannot hide behind its own compare.
   logic [TICK_CNT_W-1:0] tick_span;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_span <= '0;
      end else if (ms_tick) begin
         tick_span <= 14'h0001;
      end else begin
         tick_span <= tick_span + 14'h0001;
      end
   end

   tick_len_a: assert property (ms_tick |->
      tick_span == TICK_CNT_W'(TICK_CYCLES))
      else $error("millisecond tick spacing is wrong");
   blink_hold_a: assert property (!ms_tick |=> $stable(blink_phase))
      else $error("blink phase moved between ticks");

   forced_off_a: assert property (ind_ctrl[3:0] == 4'h8 |=>
      !indicator_outputs[0] && !indicator_oe_n[0])
      else $error("forced off output not driven low");
   lp_zero_a: assert property (ind_ctrl[3:2] != PFX_FORCE && low_power |=>
      indicator_outputs[0] == $past(off_value[0]) &&
      indicator_oe_n[0] == $past(off_value[1]))
      else $error("low power output zero ignores its off value");

   pair_drive_a: assert property (ind_ctrl[3:2] == PFX_DUAL && !low_power
      |=> !indicator_oe_n[0] && !indicator_oe_n[1])
      else $error("dual pair output released");

   sequence full_mix_10;
      (ind_ctrl[3:0] == 4'hf && !low_power && link10 && !link100 &&
       !gig_link && !activity && mix_ratio_even == MIX_FULL &&
       mix_ratio_odd == MIX_FULL)[*2];
   endsequence

   mode4_10_a: assert property (full_mix_10 |=>
      indicator_outputs[0] && indicator_outputs[1])
      else $error("fourth dual mode 10 mix wrong");

endmodule : lsi_top

// >>> verification/lsi_lamp_model.sv
// Lamp model that resolves each indicator pin as the lamps see it.
`timescale 1ns/1ps
module lsi_lamp_model
   import lsi_pkg::*;
(
   input  wire logic                       core_clk, // Core clock.
   input  wire logic [lsi_pkg::NUM_OUT-1:0] level,    // Driven level.
   input  wire logic [lsi_pkg::NUM_OUT-1:0] oe_n,     // Low while driven.
   output logic [lsi_pkg::NUM_OUT-1:0]      pin       // Wire level.
);
   import lsi_pkg::*;
   logic [NUM_OUT-1:0] last;
   // Keep the last driven level of each pin.
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < NUM_OUT; i++) begin
         if (!oe_n[i]) last[i] <= level[i];
      end
   end
   // No pull exists, so a released pin shows the inverse of its last level.
   always_comb begin
      for (int i = 0; i < NUM_OUT; i++) begin
         pin[i] = oe_n[i] ? ~last[i] : level[i];
      end
   end
endmodule : lsi_lamp_model

// >>> verification/lsi_top_tb_top.sv
// Self-checking bench for the status indicator block.
`timescale 1ns/1ps
module lsi_top_tb_top;
   import lsi_pkg::*;
   localparam int TK = 4;
   logic              core_clk = 1'b0;
   logic              arst_n = 1'b0;
   logic              tx_act = 1'b0, rx_act = 1'b0;
   logic [3:0]        lk = 4'h0;
   logic              sw_reset = 1'b0, power_down = 1'b0;
   logic              energy_detect = 1'b0;
   logic [CTRL_W-1:0] ind_ctrl = '0;
   logic [3:0]        r_even = 4'h0, r_odd = 4'h0;
   logic [1:0]        s_odd = 2'h0, s_even = 2'h0, b_sel = 2'h0;
   logic [11:0]       off_value = 12'h000;
   logic [5:0]        outs, oe_n, pin;
   int                error_cnt = 0, num_checks = 0, hi, rs;
   // Half period of 50 ns gives the 10 MHz core clock.
   always #50 core_clk = ~core_clk;
   lsi_top #(.TICK_CYCLES(TK)) u_dut (.core_clk(core_clk), .arst_n(arst_n),
      .tx_act(tx_act), .rx_act(rx_act), .link10(lk[0]), .link100(lk[1]),
      .link1000(lk[2]), .fiber_link(lk[3]), .full_duplex(1'b0),
      .collision(1'b0), .sw_reset(sw_reset), .power_down(power_down),
      .energy_detect(energy_detect), .ind_ctrl(ind_ctrl),
      .mix_ratio_even(r_even), .mix_ratio_odd(r_odd), .seg_odd_sel(s_odd),
      .seg_even_sel(s_even), .blink_sel(b_sel), .off_value(off_value),
      .indicator_outputs(outs), .indicator_oe_n(oe_n));
   lsi_lamp_model u_lamp (.core_clk(core_clk), .level(outs), .oe_n(oe_n),
      .pin(pin));
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_cnt(input int got, input int exp);
      num_checks++;
      if (got != exp) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_cnt
   task automatic go(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : go
   // Counts lit cycles and rising edges of one lamp over n cycles.
   task automatic count(input int b, input int n);
      logic p;
      hi = 0;
      rs = 0;
      p = pin[b];
      repeat (n) begin
         go(1);
         hi += (pin[b] === 1'b1);
         rs += (pin[b] === 1'b1 && p === 1'b0);
         p = pin[b];
      end
   endtask : count
   task automatic t_force;
      for (int c = 8; c < 11; c++) begin
         @(posedge core_clk) ind_ctrl[3:0] <= c[3:0];
         go(2);
         chk({oe_n[0], outs[0]}, (c == 8) ? 6'h0 : (c == 9) ? 6'h1 : 6'h2);
      end
      @(posedge core_clk) ind_ctrl[3:0] <= 4'h9;
      power_down <= 1'b1;
      go(2);
      chk({oe_n[0], outs[0]}, 6'h1);
      @(posedge core_clk) ind_ctrl[3:0] <= 4'hb;
      count(0, 700);
      chk_cnt(hi, 0);
      @(posedge core_clk) power_down <= 1'b0;
      go(4);
      count(0, 2 * 84 * TK);
      chk_cnt(hi, 84 * TK);
      $display("test force done");
   endtask : t_force
   task automatic t_power;
      @(posedge core_clk) ind_ctrl[3:0] <= 4'h0;
      lk <= 4'h1;
      for (int s = 0; s < 3; s++) begin
         @(posedge core_clk) {energy_detect, power_down, sw_reset} <= 3'h1 << s;
         off_value[1:0] <= s[1:0] + 2'h1;
         go(2);
         chk({oe_n[0], outs[0]}, {4'h0, s[1:0] + 2'h1});
      end
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk) {energy_detect, power_down, sw_reset} <= 3'h0;
         lk <= (i == 0) ? 4'h1 : (i == 1) ? 4'h8 : 4'h0;
         go(2);
         chk({oe_n[0], outs[0]}, (i < 2) ? 6'h1 : 6'h0);
      end
      $display("test power done");
   endtask : t_power
   task automatic t_compound;
      @(posedge core_clk) ind_ctrl[7:0] <= 8'h03;
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk) {tx_act, rx_act} <= i[1:0];
         lk <= 4'h1 << i;
         go(2);
         chk(outs[1:0], {5'h0, (i < 3)} << 1 | (i != 0));
      end
      @(posedge core_clk) {tx_act, rx_act} <= 2'h0;
      $display("test compound done");
   endtask : t_compound
   task automatic t_speed;
      @(posedge core_clk) ind_ctrl[3:0] <= CODE_SPEED;
      s_odd <= 2'h1;
      s_even <= 2'h0;
      for (int sp = 0; sp < 4; sp++) begin
         @(posedge core_clk) lk <= (sp == 0) ? 4'h0 : 4'h1 << (sp - 1);
         go(4);
         count(0, 4 * (170 + 84) * TK);
         chk_cnt(hi, sp * 170 * TK);
         chk_cnt(rs, sp);
      end
      $display("test speed done");
   endtask : t_speed
   task automatic t_dual;
      logic [7:0] tab [2];
      tab[0] = 8'b01111000;
      tab[1] = 8'b01101100;
      @(posedge core_clk) ind_ctrl <= {3{8'h9c}};
      r_even <= 4'h3;
      r_odd <= 4'h5;
      go(4);
      count(0, 8);
      chk_cnt(hi, 3);
      count(1, 8);
      chk_cnt(hi, 5);
      @(posedge core_clk) ind_ctrl[3:0] <= 4'hd;
      r_even <= MIX_FULL;
      r_odd <= MIX_FULL;
      go(4);
      count(0, 2 * 84 * TK);
      chk_cnt(hi, 84 * TK);
      for (int m = 0; m < 2; m++) begin
         for (int sp = 0; sp < 4; sp++) begin
            @(posedge core_clk) ind_ctrl <= {3{4'h9, 4'he + m[3:0]}};
            lk <= (sp == 0) ? 4'h0 : 4'h1 << (sp - 1);
            go(4);
            chk(outs, {3{tab[m][2*sp +: 2]}});
            chk(oe_n, 6'h00);
         end
      end
      $display("test dual done");
   endtask : t_dual
   // A hang ends the run through the closing report.
   initial begin
      repeat (100000) @(posedge core_clk);
      error_cnt++;
      summarize();
   end
   // Reset is held for sixteen cycles, then the scenarios run in turn.
   initial begin
      go(16);
      chk(outs, 6'h00);
      @(posedge core_clk) arst_n <= 1'b1;
      t_force();
      t_power();
      t_compound();
      t_speed();
      t_dual();
      summarize();
   end
endmodule : lsi_top_tb_top
